/* File: src/ddrtac_pkg.sv */
package ddrtac_pkg;
   // ==========================================================
   // register map, byte addresses on the low address bits
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_BANK_CFG = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_TIM2 = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_AGING = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
   // ==========================================================
   // bank configuration: only the timing write unlock bit is held
   localparam int UNLOCK_BIT = 15;
   localparam logic UNLOCK_RST = 1'h0;
   // ==========================================================
   // second timing set fields
   localparam int XSNR_LSB = 16;
   localparam int XSNR_W = 7;
   localparam int XSRD_LSB = 8;
   localparam int XSRD_W = 8;
   localparam int RTP_LSB = 5;
   localparam int RTP_W = 3;
   localparam int CKE_LSB = 0;
   localparam int CKE_W = 5;
   localparam int RSVD_LSB = 23;
   localparam int RSVD_W = 2;
   localparam int ZERO_LSB = 25;
   localparam logic [XSNR_W-1:0] XSNR_RST = 7'h1D;
   localparam logic [XSRD_W-1:0] XSRD_RST = 8'hF1;
   localparam logic [RTP_W-1:0] RTP_RST = 3'h2;
   localparam logic [CKE_W-1:0] CKE_RST = 5'h05;
   localparam logic [RSVD_W-1:0] RSVD_RST = 2'h0;
   // ==========================================================
   // aging threshold
   localparam int AGE_W = 8;
   localparam logic [AGE_W-1:0] AGE_RST = 8'hFF;
   localparam logic [AGE_W-1:0] AGE_OFF = 8'hFF;
   // ==========================================================
   // gap counters
   localparam int CNT_W = 8;
   localparam int NGAP = 4;
   localparam int GAP_XSNR = 0;
   localparam int GAP_XSRD = 1;
   localparam int GAP_RTP = 2;
   localparam int GAP_CKE = 3;
   // ==========================================================
   // bus encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // ==========================================================
   // command kinds offered by the scheduler
   typedef enum logic [1:0] {
      CMD_OTHER = 2'h0,
      CMD_READ = 2'h1,
      CMD_PRECH = 2'h2
   } ddrtac_cmd_t;
endpackage : ddrtac_pkg

/* File: src/ddrtac_age_if.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// link between the top and the aging counter
interface ddrtac_age_if;
   logic xfer;
   logic oldest_valid;
   logic retire;
   logic [ddrtac_pkg::AGE_W-1:0] thr;
   logic boost;
   logic [ddrtac_pkg::AGE_W-1:0] count;
   modport top (output xfer, output oldest_valid, output retire, output thr,
      input boost, input count);
   modport age (input xfer, input oldest_valid, input retire, input thr,
      output boost, output count);
endinterface : ddrtac_age_if
`default_nettype wire

/* File: src/ddrtac_age.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// anti-starvation transfer counter
module ddrtac_age (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // top side
   ddrtac_age_if.age a
);
   logic [ddrtac_pkg::AGE_W-1:0] cnt_q, cnt_d;
   logic boost_q, boost_d;

   // next count and promotion pulse
   always_comb begin
      cnt_d = cnt_q;
      boost_d = 1'b0;
      if (a.retire || !a.oldest_valid) begin
         cnt_d = '0;
      end else if (a.xfer && a.thr != ddrtac_pkg::AGE_OFF) begin
         if (cnt_q >= a.thr) begin
            boost_d = 1'b1;
            cnt_d = '0;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   // register the counter
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cnt_q <= '0;
         boost_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         boost_q <= boost_d;
      end
   end

   assign a.boost = boost_q;
   assign a.count = cnt_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   age_trigger_a: assert property (a.xfer && a.oldest_valid && !a.retire &&
      a.thr != ddrtac_pkg::AGE_OFF && cnt_q == a.thr |=> boost_q)
      else $error("promotion missing at threshold");
   age_early_a: assert property ($rose(boost_q) |-> $past(cnt_q) >= $past(a.thr))
      else $error("promotion before threshold reached");
   age_off_a: assert property (a.thr == ddrtac_pkg::AGE_OFF |=> !boost_q)
      else $error("promotion while aging disabled");
   age_restart_a: assert property (a.retire || boost_d |=> cnt_q == '0)
      else $error("transfer count not restarted");
   age_boost_c: cover property (boost_q);
endmodule : ddrtac_age
`default_nettype wire

/* File: src/ddrtac_top.sv */
// Notes on behaviour
// - timing register two takes writes only while the unlock bit is one
// - after self-refresh exit, non-read commands wait field 22-16 plus one cycles
// - after self-refresh exit, reads wait field 15-8 plus one cycles
// - read to following precharge spaced by field 7-5 plus one cycles
// - clock-enable transitions spaced by field 4-0 plus one cycles
// - bits 31-25 read zero; bits 24-23 reserved, zero after reset
// - oldest queued command is promoted after the programmed transfer count
// - aging threshold N promotes after N plus one transfers
// - aging threshold all ones disables promotion entirely
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ddrtac_top (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // scheduler command handshake
   input wire logic CMD_REQ,
   input wire logic [1:0] CMD_KIND,
   output logic CMD_GRANT,
   output logic [1:0] CMD_GRANT_KIND,
   // self-refresh and clock enable
   input wire logic SR_EXIT,
   input wire logic CKE_REQ,
   output logic DDR_CKE,
   // command queue aging
   input wire logic XFER_DONE,
   input wire logic OLDEST_VALID,
   input wire logic OLDEST_RETIRE,
   output logic OLDEST_BOOST
);
   // ==========================================================
   // bus address phase capture
   logic wr_pend_q, wr_pend_d;
   logic [ddrtac_pkg::ADDR_W-1:0] wr_addr_q, wr_addr_d;
   logic [31:0] rdata_q, rdata_d;
   logic ready_q;
   logic addr_ok;
   logic [ddrtac_pkg::ADDR_W-1:0] addr_lo;

   // ==========================================================
   // register state
   logic unlock_q, unlock_d;
   logic [ddrtac_pkg::XSNR_W-1:0] xsnr_q, xsnr_d;
   logic [ddrtac_pkg::XSRD_W-1:0] xsrd_q, xsrd_d;
   logic [ddrtac_pkg::RTP_W-1:0] rtp_q, rtp_d;
   logic [ddrtac_pkg::CKE_W-1:0] tcke_q, tcke_d;
   logic [ddrtac_pkg::RSVD_W-1:0] rsvd_q, rsvd_d;
   logic [ddrtac_pkg::AGE_W-1:0] age_thr_q, age_thr_d;
   logic [31:0] tim2_word;

   // ==========================================================
   // command gating state
   logic grant_q, grant_d;
   logic [1:0] gkind_q, gkind_d;
   logic cke_q, cke_d;
   logic kind_ok;
   logic [ddrtac_pkg::NGAP-1:0] gap_load;
   logic [ddrtac_pkg::NGAP-1:0] gap_busy;
   logic [ddrtac_pkg::CNT_W-1:0] gap_val [ddrtac_pkg::NGAP];

   ddrtac_age_if age_if ();

   // ==========================================================
   // address phase decode
   assign addr_ok = HSEL && HREADY && HTRANS[1];
   assign addr_lo = HADDR[ddrtac_pkg::ADDR_W-1:0];
   assign tim2_word = {7'h00, rsvd_q, xsnr_q, xsrd_q, rtp_q, tcke_q};

   // next bus state and read data, unmapped reads return zero
   always_comb begin
      wr_pend_d = addr_ok && HWRITE && HSIZE == ddrtac_pkg::HSIZE_WORD;
      wr_addr_d = addr_lo;
      rdata_d = rdata_q;
      if (addr_ok && !HWRITE) begin
         case (addr_lo)
            ddrtac_pkg::ADDR_BANK_CFG: rdata_d = 32'(unlock_q) << ddrtac_pkg::UNLOCK_BIT;
            ddrtac_pkg::ADDR_TIM2: rdata_d = tim2_word;
            ddrtac_pkg::ADDR_AGING: rdata_d = {24'h000000, age_thr_q};
            ddrtac_pkg::ADDR_STATUS: rdata_d = {19'h00000, cke_q, gap_busy, age_if.count};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   // register the bus state
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
         rdata_q <= 32'h00000000;
         ready_q <= 1'b0;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rdata_q <= rdata_d;
         ready_q <= 1'b1;
      end
   end

   // ==========================================================
   // register writes in the data phase
   always_comb begin
      unlock_d = unlock_q;
      xsnr_d = xsnr_q;
      xsrd_d = xsrd_q;
      rtp_d = rtp_q;
      tcke_d = tcke_q;
      rsvd_d = rsvd_q;
      age_thr_d = age_thr_q;
      if (wr_pend_q) begin
         case (wr_addr_q)
            ddrtac_pkg::ADDR_BANK_CFG: unlock_d = HWDATA[ddrtac_pkg::UNLOCK_BIT];
            ddrtac_pkg::ADDR_TIM2: begin
               if (unlock_q) begin
                  xsnr_d = HWDATA[ddrtac_pkg::XSNR_LSB +: ddrtac_pkg::XSNR_W];
                  xsrd_d = HWDATA[ddrtac_pkg::XSRD_LSB +: ddrtac_pkg::XSRD_W];
                  rtp_d = HWDATA[ddrtac_pkg::RTP_LSB +: ddrtac_pkg::RTP_W];
                  tcke_d = HWDATA[ddrtac_pkg::CKE_LSB +: ddrtac_pkg::CKE_W];
                  rsvd_d = HWDATA[ddrtac_pkg::RSVD_LSB +: ddrtac_pkg::RSVD_W];
               end
            end
            ddrtac_pkg::ADDR_AGING: age_thr_d = HWDATA[ddrtac_pkg::AGE_W-1:0];
            default: unlock_d = unlock_q;
         endcase
      end
   end

   // register the programmable state
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         unlock_q <= ddrtac_pkg::UNLOCK_RST;
         xsnr_q <= ddrtac_pkg::XSNR_RST;
         xsrd_q <= ddrtac_pkg::XSRD_RST;
         rtp_q <= ddrtac_pkg::RTP_RST;
         tcke_q <= ddrtac_pkg::CKE_RST;
         rsvd_q <= ddrtac_pkg::RSVD_RST;
         age_thr_q <= ddrtac_pkg::AGE_RST;
      end else begin
         unlock_q <= unlock_d;
         xsnr_q <= xsnr_d;
         xsrd_q <= xsrd_d;
         rtp_q <= rtp_d;
         tcke_q <= tcke_d;
         rsvd_q <= rsvd_d;
         age_thr_q <= age_thr_d;
      end
   end

   // ==========================================================
   // gap counter loads and values
   assign gap_load[ddrtac_pkg::GAP_XSNR] = SR_EXIT;
   assign gap_load[ddrtac_pkg::GAP_XSRD] = SR_EXIT;
   assign gap_load[ddrtac_pkg::GAP_RTP] = grant_d && gkind_d == ddrtac_pkg::CMD_READ;
   assign gap_load[ddrtac_pkg::GAP_CKE] = cke_d != cke_q;
   assign gap_val[ddrtac_pkg::GAP_XSNR] = {1'b0, xsnr_q};
   assign gap_val[ddrtac_pkg::GAP_XSRD] = xsrd_q;
   assign gap_val[ddrtac_pkg::GAP_RTP] = {5'h00, rtp_q};
   assign gap_val[ddrtac_pkg::GAP_CKE] = {3'h0, tcke_q};

   // one down counter per gap, busy while nonzero
   for (genvar i = 0; i < ddrtac_pkg::NGAP; i++) begin : g_gap
      logic [ddrtac_pkg::CNT_W-1:0] cnt_q, cnt_d;
      always_comb begin
         cnt_d = cnt_q;
         if (gap_load[i]) begin
            cnt_d = gap_val[i];
         end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 8'h01;
         end
      end
      always_ff @(posedge CLK or negedge RESETN) begin
         if (!RESETN) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_d;
         end
      end
      assign gap_busy[i] = cnt_q != '0;
   end

   // ==========================================================
   // grant and clock enable decisions
   always_comb begin
      case (CMD_KIND)
         ddrtac_pkg::CMD_READ: kind_ok = !gap_busy[ddrtac_pkg::GAP_XSRD];
         ddrtac_pkg::CMD_PRECH: kind_ok = !gap_busy[ddrtac_pkg::GAP_XSNR] &&
            !gap_busy[ddrtac_pkg::GAP_RTP];
         default: kind_ok = !gap_busy[ddrtac_pkg::GAP_XSNR];
      endcase
      grant_d = CMD_REQ && !grant_q && !SR_EXIT && kind_ok;
      gkind_d = grant_d ? CMD_KIND : gkind_q;
      cke_d = gap_busy[ddrtac_pkg::GAP_CKE] ? cke_q : CKE_REQ;
   end

   // register grant and clock enable
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         grant_q <= 1'b0;
         gkind_q <= ddrtac_pkg::CMD_OTHER;
         cke_q <= 1'b0;
      end else begin
         grant_q <= grant_d;
         gkind_q <= gkind_d;
         cke_q <= cke_d;
      end
   end

   // ==========================================================
   // aging counter
   assign age_if.xfer = XFER_DONE;
   assign age_if.oldest_valid = OLDEST_VALID;
   assign age_if.retire = OLDEST_RETIRE;
   assign age_if.thr = age_thr_q;

   ddrtac_age u_age (
      .CLK(CLK),
      .RESETN(RESETN),
      .a(age_if)
   );

   // ==========================================================
   // outputs
   assign HRDATA = rdata_q;
   assign HREADYOUT = ready_q;
   assign HRESP = 1'b0;
   assign CMD_GRANT = grant_q;
   assign CMD_GRANT_KIND = gkind_q;
   assign DDR_CKE = cke_q;
   assign OLDEST_BOOST = age_if.boost;

   // ==========================================================
   // helper counters: edges since each event, saturating
   logic [7:0] since_srx_q, since_rd_q, since_cke_q;
   logic rd_phase_q;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         since_srx_q <= 8'hFF;
         since_rd_q <= 8'hFF;
         since_cke_q <= 8'hFF;
         rd_phase_q <= 1'b0;
      end else begin
         since_srx_q <= SR_EXIT ? 8'h00 : since_srx_q + 8'(since_srx_q != 8'hFF);
         since_rd_q <= gap_load[ddrtac_pkg::GAP_RTP] ? 8'h00 :
            since_rd_q + 8'(since_rd_q != 8'hFF);
         since_cke_q <= gap_load[ddrtac_pkg::GAP_CKE] ? 8'h00 :
            since_cke_q + 8'(since_cke_q != 8'hFF);
         rd_phase_q <= addr_ok && !HWRITE && addr_lo == ddrtac_pkg::ADDR_TIM2;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   locked_write_a: assert property (wr_pend_q && wr_addr_q == ddrtac_pkg::ADDR_TIM2 &&
      !unlock_q |=> $stable(tim2_word))
      else $error("timing register changed while locked");
   nonread_gap_a: assert property (grant_d && CMD_KIND != ddrtac_pkg::CMD_READ |->
      !SR_EXIT && since_srx_q >= {1'b0, xsnr_q})
      else $error("non-read too soon after self-refresh exit");
   read_gap_a: assert property (grant_d && CMD_KIND == ddrtac_pkg::CMD_READ |->
      !SR_EXIT && since_srx_q >= xsrd_q)
      else $error("read too soon after self-refresh exit");
   rtp_gap_a: assert property (grant_d && CMD_KIND == ddrtac_pkg::CMD_PRECH |->
      since_rd_q >= {5'h00, rtp_q})
      else $error("precharge too soon after read");
   cke_gap_a: assert property ($changed(cke_q) |-> $past(since_cke_q) >= {3'h0, tcke_q})
      else $error("clock enable toggled too soon");
   zero_bits_a: assert property (rd_phase_q |-> HRDATA[31:ddrtac_pkg::ZERO_LSB] == 7'h00)
      else $error("timing register upper bits not zero");
   grant_once_a: assert property (grant_q |=> !grant_q)
      else $error("grant held for two cycles");

   read_grant_c: cover property (grant_q && gkind_q == ddrtac_pkg::CMD_READ);
   prech_after_rd_c: cover property (grant_d && CMD_KIND == ddrtac_pkg::CMD_PRECH &&
      since_rd_q < 8'h08);
   cke_toggle_c: cover property ($changed(cke_q));
   locked_write_c: cover property (wr_pend_q && wr_addr_q == ddrtac_pkg::ADDR_TIM2 && !unlock_q);
endmodule : ddrtac_top
`default_nettype wire

/* File: verif/ddrtac_mem.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// memory-side monitor: counts commands and clock-enable edges that arrive too early
module ddrtac_mem (
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // pins as the memory sees them
   input wire logic grant,
   input wire logic [1:0] kind,
   input wire logic sr_exit,
   input wire logic cke,
   // timing set programmed into the controller
   input wire logic [31:0] tim,
   // early arrivals seen
   output logic [7:0] viol
);
   int cyc;
   int t_sr;
   int t_rd;
   int t_ck;
   logic cke_q;
   // grant and cke are registered, so seen one edge after they change; exit is seen on time
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cyc = 0;
         t_sr = -1000;
         t_rd = -1000;
         t_ck = -1000;
         cke_q = 1'b0;
         viol <= 8'h00;
      end else begin
         cyc = cyc + 1;
         if (sr_exit) t_sr = cyc;
         // fields cast to int so the negative start stamps stay signed
         if (grant && kind != 2'h1 && cyc < t_sr + int'(tim[22:16]) + 2)
            viol <= viol + 8'h01;
         if (grant && kind == 2'h1 && cyc < t_sr + int'(tim[15:8]) + 2)
            viol <= viol + 8'h01;
         if (grant && kind == 2'h2 && cyc < t_rd + int'(tim[7:5]) + 1)
            viol <= viol + 8'h01;
         if (grant && kind == 2'h1) t_rd = cyc;
         if (cke !== cke_q) begin
            if (cyc < t_ck + int'(tim[4:0]) + 1) viol <= viol + 8'h01;
            t_ck = cyc;
            cke_q = cke;
         end
      end
   end
endmodule : ddrtac_mem
`default_nettype wire

/* File: verif/tb_ddr2_timing_and_aging_ctl.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_ddr2_timing_and_aging_ctl;
   typedef struct packed {logic w; logic [31:0] a; logic [31:0] d;} ddrtac_row_t;
   // ==========================================================
   // register rows: writes carry data, reads carry the expected value
   localparam ddrtac_row_t ROWS [10] = '{
      '{1'b1, 32'h04, 32'hFFFFFFFF}, '{1'b0, 32'h04, 32'h001DF145},
      '{1'b1, 32'h00, 32'hFFFFFFFF}, '{1'b0, 32'h00, 32'h00008000},
      '{1'b1, 32'h04, 32'hFFFFFFFF}, '{1'b0, 32'h04, 32'h01FFFFFF},
      '{1'b1, 32'h08, 32'hFFFFFF03}, '{1'b0, 32'h08, 32'h00000003},
      '{1'b1, 32'h10, 32'h12345678}, '{1'b0, 32'h10, 32'h00000000}};
   logic clk, rstn, hsel, hwrite, hready, hresp, cmd_req, grant, sr_exit, cke_req, cke;
   logic xfer, oval, oret, boost;
   logic [31:0] haddr, hwdata, hrdata, rd, tim_exp;
   logic [1:0] htrans, cmd_kind, gkind;
   logic [2:0] hsize;
   logic [7:0] viol;
   int err_count, n_checks, cyc, n, f, h;
   ddrtac_top u_dut (.CLK(clk), .RESETN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .CMD_REQ(cmd_req), .CMD_KIND(cmd_kind),
      .CMD_GRANT(grant), .CMD_GRANT_KIND(gkind), .SR_EXIT(sr_exit), .CKE_REQ(cke_req),
      .DDR_CKE(cke), .XFER_DONE(xfer), .OLDEST_VALID(oval), .OLDEST_RETIRE(oret),
      .OLDEST_BOOST(boost));
   ddrtac_mem u_mem (.CLK(clk), .RESETN(rstn), .grant(grant), .kind(gkind),
      .sr_exit(sr_exit), .cke(cke), .tim(tim_exp), .viol(viol));
   // ==========================================================
   // clock, timeout and helpers
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 6000) begin
         err_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one single word transfer: address phase, then data phase
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= ddrtac_pkg::HSIZE_WORD;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask : ahb
   // hold a command request until its grant is seen; n counts edges waited
   task automatic cmd(input logic [1:0] k, output int nn);
      cmd_req <= 1'b1;
      cmd_kind <= k;
      nn = 0;
      do begin
         @(posedge clk);
         nn++;
      end while (grant !== 1'b1 && nn < 500);
      cmd_req <= 1'b0;
   endtask : cmd
   task automatic srcmd(input logic [1:0] k, output int nn);
      fork
         begin
            sr_exit <= 1'b1;
            @(posedge clk);
            sr_exit <= 1'b0;
         end
         cmd(k, nn);
      join
   endtask : srcmd
   // transfers with the oldest entry valid; one slot may be a retire instead
   task automatic age(input int cnt, input int ret, output int first, output int hits);
      first = 0;
      hits = 0;
      oval <= 1'b1;
      @(posedge clk);
      for (int i = 1; i <= cnt; i++) begin
         xfer <= (i != ret);
         oret <= (i == ret);
         @(posedge clk);
         xfer <= 1'b0;
         oret <= 1'b0;
         repeat (2) begin
            @(posedge clk);
            if (boost === 1'b1) begin
               hits++;
               if (first == 0) first = i;
            end
         end
      end
      oval <= 1'b0;
      @(posedge clk);
   endtask : age
   // ==========================================================
   // main sequence
   initial begin
      {rstn, hsel, hwrite, cmd_req, sr_exit, cke_req, xfer, oval, oret} = '0;
      {haddr, hwdata, htrans, cmd_kind, hsize} = '0;
      tim_exp = 32'h001DF145;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      foreach (ROWS[i]) begin
         ahb(ROWS[i].w, ROWS[i].a, ROWS[i].d, rd);
         if (!ROWS[i].w) check(rd, ROWS[i].d);
      end
      // xsnr 3, xsrd 6, rtp 5, cke 4
      ahb(1'b1, 32'h04, 32'h000306A4, rd);
      tim_exp = 32'h000306A4;
      @(posedge clk);
      srcmd(2'h0, n);
      check(n >= 6 && n <= 7, 1'b1);
      @(posedge clk);
      srcmd(2'h2, n);
      check(n >= 6 && n <= 7, 1'b1);
      @(posedge clk);
      srcmd(2'h1, n);
      check(n >= 9 && n <= 10, 1'b1);
      @(posedge clk);
      cmd(2'h1, n);
      @(posedge clk);
      cmd(2'h2, n);
      check(n >= 5 && n <= 6, 1'b1);
      check(gkind, 2'h2);
      @(posedge clk);
      cmd(2'h1, n);
      @(posedge clk);
      cmd(2'h0, n);
      check(n, 2);
      cke_req <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cke !== 1'b1 && n < 100);
      cke_req <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cke !== 1'b0 && n < 100);
      check(n >= 5 && n <= 6, 1'b1);
      age(10, 0, f, h);
      check(f, 4);
      check(h, 2);
      age(7, 3, f, h);
      check(f, 7);
      check(h, 1);
      ahb(1'b1, 32'h08, 32'h00000000, rd);
      age(3, 0, f, h);
      check(h, 3);
      ahb(1'b1, 32'h08, 32'h000000FE, rd);
      age(256, 0, f, h);
      check(f, 255);
      check(h, 1);
      ahb(1'b1, 32'h08, 32'h000000FF, rd);
      age(20, 0, f, h);
      check(h, 0);
      check(viol, 0);
      // second reset in mid-run, with the clock enable wanted high
      cke_req <= 1'b1;
      repeat (3) @(posedge clk);
      rstn <= 1'b0;
      @(posedge clk);
      check({hready, hresp, grant, cke, boost}, 5'h00);
      check(hrdata, 32'h00000000);
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      cke_req <= 1'b0;
      tim_exp = 32'h001DF145;
      @(posedge clk);
      ahb(1'b0, 32'h08, 32'h00000000, rd);
      check(rd, 32'h000000FF);
      ahb(1'b1, 32'h04, 32'h00000000, rd);
      ahb(1'b0, 32'h04, 32'h00000000, rd);
      check(rd & 32'hFE7FFFFF, 32'h001DF145);
      summarize();
   end
endmodule : tb_ddr2_timing_and_aging_ctl
`default_nettype wire
